/* hw/iobpi_proc.sv */
// Decided for this implementation: the Wishbone slave port and the address map.
`default_nettype none
module iobpi_proc (
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  iobpi_bus_if.proc BUS,
  input wire logic [iobpi_pkg::WORD_W-1:0] DATA_SWITCH_I,
  input wire logic ILLEGAL_ADDR_I,
  input wire logic PDL_OVF_I,
  input wire logic NXM_I,
  input wire logic CLOCK_FLAG_I,
  input wire logic AR_OVF_I,
  input wire logic PC_CHANGE_I,
  output logic [7:0] BOUND_LIMIT_O,
  output logic [7:0] RELOCATION_O,
  output logic PI_CYCLE_O,
  output logic [17:0] INT_ADDR_O
);
  import iobpi_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} iobpi_state_t;

  // ****************************************
  // console switch synchroniser
  // ****************************************
  logic [35:0] sw_meta_q, sw_q;
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sw_meta_q <= WORD_RST;
      sw_q <= WORD_RST;
    end else begin
      sw_meta_q <= DATA_SWITCH_I;
      sw_q <= sw_meta_q;
    end
  end

  // ****************************************
  // state
  // ****************************************
  iobpi_state_t state_q, state_d;
  logic [31:0] instr_q, instr_d;
  logic [35:0] ar_q, ar_d, blt_q, blt_d, out_q, out_d;
  logic [17:0] blkcnt_q, blkcnt_d, addr_q, addr_d;
  logic [6:0] sel_q, sel_d, on_q, on_d, req_q, req_d, hold_q, hold_d;
  logic [3:0] cmd_q, cmd_d; // data-in, data-out, condition-out, status
  logic skip_q, skip_d, notiot_q, notiot_d, abort_q, abort_d, wrap_q, wrap_d;
  logic active_q, active_d, picyc_q, picyc_d, piovf_q, piovf_d;
  logic [2:0] chan_q, chan_d, cpu_chan_q, cpu_chan_d;
  logic [5:0] flags_q, flags_d;
  logic [2:0] en_q, en_d;
  logic [7:0] bound_q, bound_d, reloc_q, reloc_d;
  logic ack_q;
  logic [31:0] rdat_q, rdat_d;
  logic wb_hit, wb_wr;
  logic [6:0] cpu_line;
  logic [35:0] rd_word;

  assign wb_hit = WB_CYC_I & WB_STB_I & ~ack_q;
  assign wb_wr = wb_hit & WB_WE_I;
  // fault flags always ask; the others only once enabled
  assign cpu_line = ((|flags_q[2:0]) | (|(flags_q[5:3] & en_q))) ? chan_line(cpu_chan_q)
                                                                : CHAN_RST;
  // answer of the addressed device, internal ones first
  always_comb begin
    rd_word = BUS.bus_in;
    if (sel_q == PI_DEV_CODE) begin
      rd_word = {28'h0, active_q, on_q};
    end else if (sel_q == CPU_DEV_CODE) begin
      rd_word = (instr_q[IW_OP_LSB +: 3] == OP_DATA_IN) ? sw_q :
                {24'h0, cpu_chan_q, en_q, flags_q};
    end
  end

  // ****************************************
  // transfer sequence and priority system
  // ****************************************
  always_comb begin
    logic [31:0] iw;
    logic [2:0] op;
    logic [2:0] grant;
    logic [2:0] ci;
    logic [6:0] lines;
    logic [5:0] fclr;
    logic start, sample, blt_word;
    iw = wb_merge(instr_q, WB_DAT_I, WB_SEL_I);
    op = instr_q[IW_OP_LSB +: 3];
    ci = chan_q - 3'h1;
    start = 1'b0;
    sample = 1'b0;
    blt_word = 1'b0;
    fclr = 6'h00;
    grant = 3'h0;
    lines = BUS.pi_req | cpu_line;
    state_d = state_q;
    instr_d = instr_q;
    ar_d = ar_q;
    blt_d = blt_q;
    out_d = out_q;
    blkcnt_d = blkcnt_q;
    addr_d = addr_q;
    sel_d = sel_q;
    on_d = on_q;
    req_d = req_q;
    hold_d = hold_q;
    cmd_d = 4'h0;
    skip_d = skip_q;
    notiot_d = notiot_q;
    abort_d = abort_q;
    wrap_d = wrap_q;
    active_d = active_q;
    picyc_d = picyc_q;
    piovf_d = piovf_q;
    chan_d = chan_q;
    cpu_chan_d = cpu_chan_q;
    en_d = en_q;
    bound_d = bound_q;
    reloc_d = reloc_q;
    // software writes
    if (wb_wr) begin
      case (WB_ADR_I)
        REG_INSTR: begin
          if (state_q == ST_IDLE) begin
            instr_d = iw;
            start = (iw[IW_TOP_LSB +: 3] == IOT_PATTERN);
            notiot_d = ~start;
          end
        end
        REG_AR_LO: ar_d[31:0] = wb_merge(ar_q[31:0], WB_DAT_I, WB_SEL_I);
        REG_AR_HI: ar_d[35:32] = 4'(wb_merge({28'h0, ar_q[35:32]}, WB_DAT_I, WB_SEL_I));
        REG_BLT_LO: blt_d[31:0] = wb_merge(blt_q[31:0], WB_DAT_I, WB_SEL_I);
        REG_BLT_HI: blt_d[35:32] = 4'(wb_merge({28'h0, blt_q[35:32]}, WB_DAT_I, WB_SEL_I));
        REG_BLKCNT: blkcnt_d = 18'(wb_merge({14'h0, blkcnt_q}, WB_DAT_I, WB_SEL_I));
        REG_SEQ: begin
          sample = WB_DAT_I[SEQ_SAMPLE];
          blt_word = WB_DAT_I[SEQ_BLT_WORD];
          if (WB_DAT_I[SEQ_JUMP] && picyc_q) begin
            hold_d[ci] = 1'b1;
            req_d[ci] = 1'b0;
            picyc_d = 1'b0;
            piovf_d = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          op = iw[IW_OP_LSB +: 3];
          skip_d = 1'b0;
          sel_d = iw[IW_DEV_LSB +: 7];
          out_d = ar_q;
          wrap_d = 1'b0;
          // block ops count, then run as plain data ops
          if (op == OP_BLOCK_IN || op == OP_BLOCK_OUT) begin
            blkcnt_d = blkcnt_q + 18'h1;
            wrap_d = (blkcnt_d == HALF_RST);
          end
          cmd_d[0] = (op == OP_DATA_IN) || (op == OP_BLOCK_IN);
          cmd_d[1] = (op == OP_DATA_OUT) || (op == OP_BLOCK_OUT);
          cmd_d[2] = (op == OP_COND_OUT);
          cmd_d[3] = (op == OP_COND_IN) || (op == OP_SKIP_ZERO) || (op == OP_SKIP_ONE);
          state_d = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        // internal devices act on the command cycle
        if (cmd_q[2] && sel_q == PI_DEV_CODE) begin
          if (out_q[PI_CLEAR]) begin
            on_d = CHAN_RST;
            req_d = CHAN_RST;
            hold_d = hold_d & ~hold_q; // a hold set in this cycle survives
            active_d = 1'b0;
          end
          if (out_q[PI_ON]) on_d = on_d | out_q[6:0];
          if (out_q[PI_OFF]) on_d = on_d & ~out_q[6:0];
          if (out_q[PI_SET_REQ]) req_d = req_d | (out_q[6:0] & ~hold_q);
          if (out_q[PI_ACTIVATE]) active_d = 1'b1;
          if (out_q[PI_DEACTIVATE]) active_d = 1'b0;
          if (out_q[PI_DISMISS]) begin
            hold_d = hold_d & ~(hold_q & ~(hold_q - 7'h01));
          end
        end
        if (cmd_q[2] && sel_q == CPU_DEV_CODE) begin
          cpu_chan_d = out_q[2:0];
          en_d = out_q[CPU_EN_LSB +: 3];
          if (out_q[CPU_CLR_FLAGS]) fclr = 6'h3f;
        end
        if (cmd_q[1] && sel_q == CPU_DEV_CODE) begin
          bound_d = out_q[BOUND_LSB +: 8];
          reloc_d = out_q[RELOC_LSB +: 8];
        end
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (op == OP_DATA_IN || op == OP_BLOCK_IN || op == OP_COND_IN) begin
          ar_d = rd_word;
        end
        if (op == OP_SKIP_ZERO) skip_d = ((rd_word[17:0] & instr_q[17:0]) == HALF_RST);
        if (op == OP_SKIP_ONE) skip_d = ((rd_word[17:0] & instr_q[17:0]) != HALF_RST);
        if (picyc_q && (op == OP_BLOCK_IN || op == OP_BLOCK_OUT)) begin
          if (wrap_q && !piovf_q) begin
            piovf_d = 1'b1;
            addr_d = PI_BASE_ADDR + {14'h0, chan_q, 1'b1};
          end else begin
            picyc_d = 1'b0;
            piovf_d = 1'b0;
            req_d[ci] = 1'b0;
          end
        end
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
    // request sampling at cycle starts and after block move words
    if (sample || blt_word) begin
      abort_d = 1'b0;
      req_d = req_d | (lines & on_q & ~hold_d);
    end
    req_d = req_d & ~hold_d;
    grant = first_channel(req_d, hold_d);
    if ((sample || blt_word) && active_q && !picyc_q && grant != 3'h0) begin
      picyc_d = 1'b1;
      piovf_d = 1'b0;
      chan_d = grant;
      addr_d = PI_BASE_ADDR + {14'h0, grant, 1'b0};
      if (blt_word) begin
        ar_d = blt_q;
        abort_d = 1'b1;
      end
    end
    // a new event wins over a clear in the same cycle
    flags_d = (flags_q & ~fclr) | {PC_CHANGE_I, AR_OVF_I, CLOCK_FLAG_I, NXM_I, PDL_OVF_I,
                                   ILLEGAL_ADDR_I};
    if (state_q == ST_ISSUE && cmd_q[2] && sel_q == CPU_DEV_CODE) begin
      flags_d[4] = flags_d[4] | out_q[CPU_SET_OVF];
      flags_d[5] = flags_d[5] | out_q[CPU_SET_PCCHG];
    end
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_q <= ST_IDLE;
      instr_q <= 32'h0;
      ar_q <= WORD_RST;
      blt_q <= WORD_RST;
      out_q <= WORD_RST;
      blkcnt_q <= HALF_RST;
      addr_q <= HALF_RST;
      sel_q <= CHAN_RST;
      on_q <= CHAN_RST;
      req_q <= CHAN_RST;
      hold_q <= CHAN_RST;
      cmd_q <= 4'h0;
      skip_q <= 1'b0;
      notiot_q <= 1'b0;
      abort_q <= 1'b0;
      wrap_q <= 1'b0;
      active_q <= 1'b0;
      picyc_q <= 1'b0;
      piovf_q <= 1'b0;
      chan_q <= 3'h0;
      cpu_chan_q <= 3'h0;
      flags_q <= 6'h00;
      en_q <= 3'h0;
      bound_q <= 8'h00;
      reloc_q <= 8'h00;
    end else begin
      state_q <= state_d;
      instr_q <= instr_d;
      ar_q <= ar_d;
      blt_q <= blt_d;
      out_q <= out_d;
      blkcnt_q <= blkcnt_d;
      addr_q <= addr_d;
      sel_q <= sel_d;
      on_q <= on_d;
      req_q <= req_d;
      hold_q <= hold_d;
      cmd_q <= cmd_d;
      skip_q <= skip_d;
      notiot_q <= notiot_d;
      abort_q <= abort_d;
      wrap_q <= wrap_d;
      active_q <= active_d;
      picyc_q <= picyc_d;
      piovf_q <= piovf_d;
      chan_q <= chan_d;
      cpu_chan_q <= cpu_chan_d;
      flags_q <= flags_d;
      en_q <= en_d;
      bound_q <= bound_d;
      reloc_q <= reloc_d;
    end
  end

  // ****************************************
  // wishbone read side and acknowledge
  // ****************************************
  always_comb begin
    rdat_d = rdat_q;
    if (wb_hit) begin
      case (WB_ADR_I)
        REG_INSTR: rdat_d = instr_q;
        REG_AR_LO: rdat_d = ar_q[31:0];
        REG_AR_HI: rdat_d = {28'h0, ar_q[35:32]};
        REG_BLT_LO: rdat_d = blt_q[31:0];
        REG_BLT_HI: rdat_d = {28'h0, blt_q[35:32]};
        REG_STATUS: begin
          rdat_d = 32'h0;
          rdat_d[ST_BUSY] = (state_q != ST_IDLE);
          rdat_d[ST_SKIP] = skip_q;
          rdat_d[ST_NOT_IOT] = notiot_q;
          rdat_d[ST_ACTIVE] = active_q;
          rdat_d[ST_PI_CYCLE] = picyc_q;
          rdat_d[ST_PI_OVF] = piovf_q;
          rdat_d[ST_BLT_ABORT] = abort_q;
          rdat_d[ST_ON_LSB +: 7] = on_q;
          rdat_d[ST_REQ_LSB +: 7] = req_q;
          rdat_d[ST_HOLD_LSB +: 7] = hold_q;
        end
        REG_PIADDR: rdat_d = {11'h0, chan_q, addr_q};
        REG_BLKCNT: rdat_d = {14'h0, blkcnt_q};
        default: rdat_d = 32'h0; // unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q <= wb_hit;
      rdat_q <= rdat_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;
  assign BUS.dev_sel = sel_q;
  assign BUS.cmd_data_in = cmd_q[0];
  assign BUS.cmd_data_out = cmd_q[1];
  assign BUS.cmd_cond_out = cmd_q[2];
  assign BUS.cmd_status = cmd_q[3];
  assign BUS.bus_out = out_q;
  assign BOUND_LIMIT_O = bound_q;
  assign RELOCATION_O = reloc_q;
  assign PI_CYCLE_O = picyc_q;
  assign INT_ADDR_O = addr_q;
endmodule : iobpi_proc
`default_nettype wire

/* hw/iobpi_pkg.sv */
`default_nettype none
package iobpi_pkg;
  // ****************************************
  // word and instruction layout
  // ****************************************
  localparam int unsigned WORD_W = 36;
  localparam int unsigned NCHAN = 7;
  localparam logic [2:0] IOT_PATTERN = 3'h7;
  // instruction word: bit k (0 to 13) of the instruction sits at bit 31-k, the effective address at bits 17-0
  localparam int unsigned IW_TOP_LSB = 29;
  localparam int unsigned IW_DEV_LSB = 22;
  localparam int unsigned IW_OP_LSB = 19;
  localparam logic [2:0] OP_BLOCK_IN = 3'h0;
  localparam logic [2:0] OP_DATA_IN = 3'h1;
  localparam logic [2:0] OP_BLOCK_OUT = 3'h2;
  localparam logic [2:0] OP_DATA_OUT = 3'h3;
  localparam logic [2:0] OP_COND_OUT = 3'h4;
  localparam logic [2:0] OP_COND_IN = 3'h5;
  localparam logic [2:0] OP_SKIP_ZERO = 3'h6;
  localparam logic [2:0] OP_SKIP_ONE = 3'h7;
  // internal device codes, values arbitrary
  localparam logic [6:0] CPU_DEV_CODE = 7'h00;
  localparam logic [6:0] PI_DEV_CODE = 7'h01;
  // location 40 octal
  localparam logic [17:0] PI_BASE_ADDR = 18'h00020;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [35:0] WORD_RST = 36'h0;
  localparam logic [6:0] CHAN_RST = 7'h00;
  localparam logic [17:0] HALF_RST = 18'h0;
  // ****************************************
  // software registers, byte offsets
  // ****************************************
  localparam logic [7:0] REG_INSTR = 8'h00;
  localparam logic [7:0] REG_AR_LO = 8'h04;
  localparam logic [7:0] REG_AR_HI = 8'h08;
  localparam logic [7:0] REG_BLT_LO = 8'h0c;
  localparam logic [7:0] REG_BLT_HI = 8'h10;
  localparam logic [7:0] REG_SEQ = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_PIADDR = 8'h1c;
  localparam logic [7:0] REG_BLKCNT = 8'h20;
  localparam int unsigned SEQ_SAMPLE = 0;
  localparam int unsigned SEQ_BLT_WORD = 1;
  localparam int unsigned SEQ_JUMP = 2;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_SKIP = 1;
  localparam int unsigned ST_NOT_IOT = 2;
  localparam int unsigned ST_ACTIVE = 3;
  localparam int unsigned ST_PI_CYCLE = 4;
  localparam int unsigned ST_PI_OVF = 5;
  localparam int unsigned ST_BLT_ABORT = 6;
  localparam int unsigned ST_ON_LSB = 8;
  localparam int unsigned ST_REQ_LSB = 16;
  localparam int unsigned ST_HOLD_LSB = 24;
  // ****************************************
  // condition and status words
  // ****************************************
  localparam int unsigned PI_SET_REQ = 7;
  localparam int unsigned PI_ON = 8;
  localparam int unsigned PI_OFF = 9;
  localparam int unsigned PI_ACTIVATE = 10;
  localparam int unsigned PI_DEACTIVATE = 11;
  localparam int unsigned PI_CLEAR = 12;
  localparam int unsigned PI_DISMISS = 13;
  localparam int unsigned PI_STAT_ACTIVE = 7;
  localparam int unsigned CPU_CLR_FLAGS = 3;
  localparam int unsigned CPU_EN_LSB = 4;
  localparam int unsigned CPU_SET_OVF = 7;
  localparam int unsigned CPU_SET_PCCHG = 8;
  localparam int unsigned CPU_STAT_EN_LSB = 6;
  localparam int unsigned CPU_STAT_CHAN_LSB = 9;
  localparam int unsigned BOUND_LSB = 28;
  localparam int unsigned RELOC_LSB = 10;
  localparam int unsigned UNIT_CLR_FLAG = 3;
  localparam int unsigned UNIT_STAT_FLAG = 3;

  // byte-lane merge for register writes
  function automatic logic [31:0] wb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : wb_merge

  // lowest pending channel not blocked by a hold at or below it
  function automatic logic [2:0] first_channel(input logic [6:0] req, input logic [6:0] hold);
    logic blocked;
    logic [2:0] ch;
    blocked = 1'b0;
    ch = 3'h0;
    for (int i = 0; i < NCHAN; i++) begin
      if (hold[i]) begin
        blocked = 1'b1;
      end
      if (!blocked && req[i] && ch == 3'h0) begin
        ch = 3'(i + 1);
      end
    end
    return ch;
  endfunction : first_channel

  // one-hot line for a channel number, zero for no assignment
  function automatic logic [6:0] chan_line(input logic [2:0] ch);
    return (ch == 3'h0) ? 7'h00 : 7'(7'h01 << (ch - 3'h1));
  endfunction : chan_line
endpackage : iobpi_pkg
`default_nettype wire

/* hw/iobpi_bus_if.sv */
`default_nettype none
// ****************************************
// in-out bus between processor and units
// ****************************************
interface iobpi_bus_if;
  logic [6:0] dev_sel;
  logic cmd_data_in;
  logic cmd_data_out;
  logic cmd_cond_out;
  logic cmd_status;
  logic [35:0] bus_out;
  logic [35:0] bus_in;
  logic [6:0] pi_req;
  modport proc (output dev_sel, cmd_data_in, cmd_data_out, cmd_cond_out, cmd_status, bus_out,
                input bus_in, pi_req);
  modport unit (input dev_sel, cmd_data_in, cmd_data_out, cmd_cond_out, cmd_status, bus_out,
                output bus_in, pi_req);
endinterface : iobpi_bus_if
`default_nettype wire

/* hw/iobpi_unit.sv */
`default_nettype none
module iobpi_unit #(
  parameter logic [6:0] DEV_CODE = 7'h0a
) (
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  iobpi_bus_if.unit BUS,
  input wire logic ITEM_VALID_I,
  input wire logic [iobpi_pkg::WORD_W-1:0] ITEM_DATA_I,
  output logic FETCH_O,
  output logic [iobpi_pkg::WORD_W-1:0] OUT_DATA_O,
  output logic OUT_LOAD_O
);
  import iobpi_pkg::*;

  logic [2:0] chan_q, chan_d;
  logic flag_q, flag_d;
  logic [35:0] buf_q, buf_d;
  logic [35:0] in_q, in_d;
  logic [35:0] out_q, out_d;
  logic fetch_q, fetch_d;
  logic load_q, load_d;
  logic sel;

  // ****************************************
  // unit control
  // ****************************************
  // only the addressed unit answers broadcast commands
  assign sel = (BUS.dev_sel == DEV_CODE);
  always_comb begin
    chan_d = chan_q;
    flag_d = flag_q;
    buf_d = buf_q;
    in_d = in_q;
    out_d = out_q;
    fetch_d = 1'b0;
    load_d = 1'b0;
    if (sel && BUS.cmd_cond_out) begin
      chan_d = BUS.bus_out[2:0];
      if (BUS.bus_out[UNIT_CLR_FLAG]) begin
        flag_d = 1'b0;
      end
    end
    if (sel && BUS.cmd_data_in) begin
      in_d = buf_q;
      flag_d = 1'b0;
      fetch_d = 1'b1;
    end
    if (sel && BUS.cmd_status) begin
      in_d = {32'h0, flag_q, chan_q};
    end
    if (sel && BUS.cmd_data_out) begin
      out_d = BUS.bus_out;
      load_d = 1'b1;
    end
    // a filling buffer wins over a clear in the same cycle
    if (ITEM_VALID_I) begin
      buf_d = ITEM_DATA_I;
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      chan_q <= 3'h0;
      flag_q <= 1'b0;
      buf_q <= WORD_RST;
      in_q <= WORD_RST;
      out_q <= WORD_RST;
      fetch_q <= 1'b0;
      load_q <= 1'b0;
    end else begin
      chan_q <= chan_d;
      flag_q <= flag_d;
      buf_q <= buf_d;
      in_q <= in_d;
      out_q <= out_d;
      fetch_q <= fetch_d;
      load_q <= load_d;
    end
  end

  // ****************************************
  // bus and user outputs
  // ****************************************
  assign BUS.bus_in = in_q;
  assign BUS.pi_req = flag_q ? chan_line(chan_q) : CHAN_RST;
  assign FETCH_O = fetch_q;
  assign OUT_DATA_O = out_q;
  assign OUT_LOAD_O = load_q;
endmodule : iobpi_unit
`default_nettype wire

/* test/iobpi_assertions.sv */
`default_nettype none
module iobpi_assertions (
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic [6:0] dev_sel,
  input wire logic cmd_data_in,
  input wire logic cmd_data_out,
  input wire logic cmd_cond_out,
  input wire logic cmd_status,
  input wire logic [35:0] bus_out,
  input wire logic [35:0] bus_in,
  input wire logic [6:0] pi_req,
  input wire logic PI_CYCLE_O,
  input wire logic [17:0] INT_ADDR_O,
  input wire logic FETCH_O,
  input wire logic OUT_LOAD_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] chan_q;
  logic [3:0] cmds;
  logic unit_sel;
  // the unit on this bench answers to one code only
  assign unit_sel = dev_sel == 7'h0a;
  assign cmds = {cmd_data_in, cmd_data_out, cmd_cond_out, cmd_status};
  // channel last handed to the unit, mirrors its own copy
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      chan_q <= 3'h0;
    end else if (cmd_cond_out && unit_sel) begin
      chan_q <= bus_out[2:0];
    end
  end
  default clocking @(posedge MCLK_I);
  endclocking
  default disable iff (!RESETN_I);
  // ****
  // bus and interrupt checks
  // ****
  a_one_kind: assert property ($onehot0(cmds))
    else $error("two commands at once");
  a_cmd_pulse: assert property (|cmds |=> cmds == 4'h0)
    else $error("command too long");
  a_unit_deaf: assert property ((cmd_data_in || cmd_status) && !unit_sel
    |=> $stable(bus_in)) else $error("unselected unit answered");
  a_unit_status: assert property (cmd_status && unit_sel |=> bus_in[2:0] == chan_q)
    else $error("status lacks channel");
  a_req_line: assert property (pi_req != 7'h00 |->
    pi_req == 7'(7'h01 << (chan_q - 3'h1))) else $error("request on wrong line");
  a_req_drop: assert property (cmd_data_in && unit_sel |-> ##[1:3] pi_req == 7'h00)
    else $error("request stayed up");
  a_pi_entry: assert property ($rose(PI_CYCLE_O) |-> !INT_ADDR_O[0] &&
    INT_ADDR_O inside {[18'h22:18'h2e]}) else $error("bad entry address");
  a_pi_range: assert property (PI_CYCLE_O |-> INT_ADDR_O inside {[18'h22:18'h2f]})
    else $error("address out of range");
  a_unit_fetch: assert property (cmd_data_in && unit_sel |=> FETCH_O)
    else $error("no fetch after data-in");
  a_unit_load: assert property (cmd_data_out && unit_sel |=> OUT_LOAD_O)
    else $error("no load after data-out");
  c_pi_second: cover property (PI_CYCLE_O && INT_ADDR_O[0]);
  c_unit_status: cover property (cmd_status && unit_sel);
  c_pi_entry: cover property ($rose(PI_CYCLE_O));
  c_unit_out: cover property (cmd_data_out && unit_sel);
endmodule : iobpi_assertions
`default_nettype wire

/* test/io_bus_command_and_priority_interrupt_tb.sv */
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module io_bus_command_and_priority_interrupt_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import iobpi_pkg::*;
  localparam logic [6:0] UNIT = 7'h0a;
  logic mclk, picyc, ack, fetch, oload;
  logic rst_n = 1'b0, cyc = 1'b0, we = 1'b0, ival = 1'b0;
  logic [7:0] adr = 8'h00, bound, reloc;
  logic [31:0] wdat = 32'h0, rdat, dout;
  logic [35:0] sw = 36'h9_8765_4321, item = 36'h5_0f0f_a5a5, odata;
  logic [5:0] flt = 6'h00;
  logic [17:0] iaddr;
  int bad_count = 0, checks_done = 0;
  iobpi_bus_if bus ();
  iobpi_proc iobpi_proc_inst (.MCLK_I(mclk), .RESETN_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(4'hf), .WB_DAT_O(dout),
    .WB_ACK_O(ack), .BUS(bus), .DATA_SWITCH_I(sw), .ILLEGAL_ADDR_I(flt[0]), .PDL_OVF_I(flt[1]),
    .NXM_I(flt[2]), .CLOCK_FLAG_I(flt[3]), .AR_OVF_I(flt[4]), .PC_CHANGE_I(flt[5]),
    .BOUND_LIMIT_O(bound), .RELOCATION_O(reloc), .PI_CYCLE_O(picyc), .INT_ADDR_O(iaddr));
  iobpi_unit #(.DEV_CODE(UNIT)) iobpi_unit_inst (.MCLK_I(mclk), .RESETN_I(rst_n), .BUS(bus),
    .ITEM_VALID_I(ival), .ITEM_DATA_I(item), .FETCH_O(fetch), .OUT_DATA_O(odata),
    .OUT_LOAD_O(oload));
  iobpi_assertions iobpi_assertions_inst (.MCLK_I(mclk), .RESETN_I(rst_n),
    .dev_sel(bus.dev_sel), .cmd_data_in(bus.cmd_data_in), .cmd_data_out(bus.cmd_data_out),
    .cmd_cond_out(bus.cmd_cond_out), .cmd_status(bus.cmd_status), .bus_out(bus.bus_out),
    .bus_in(bus.bus_in), .pi_req(bus.pi_req), .PI_CYCLE_O(picyc), .INT_ADDR_O(iaddr),
    .FETCH_O(fetch), .OUT_LOAD_O(oload));
  // ****
  // bus helpers
  // ****
  // one classic cycle, held until ack is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge mclk);
    while (ack !== 1'b1) @(posedge mclk);
    rdat = dout;
    cyc <= 1'b0;
  endtask : wb
  // issue a transfer and poll until it is done, status is left in rdat
  task automatic io_transfer_instruction(input logic [6:0] dv, input logic [2:0] op, input logic [17:0] e);
    wb(1'b1, REG_INSTR, {3'h7, dv, op, 1'b0, e});
    do begin
      wb(1'b0, REG_STATUS, 32'h0);
    end while (rdat[ST_BUSY] !== 1'b0);
  endtask : io_transfer_instruction
  task automatic ar(input logic [35:0] v);
    wb(1'b1, REG_AR_LO, v[31:0]);
    wb(1'b1, REG_AR_HI, {28'h0, v[35:32]});
  endtask : ar
  task automatic put_item();
    ival <= 1'b1;
    @(posedge mclk);
    ival <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : put_item
  // ****
  // scenarios
  // ****
  task automatic t_unit();
    ar(36'h3);
    io_transfer_instruction(UNIT, OP_COND_OUT, 18'h0);
    put_item();
    `CHK("req line", 7'h04, bus.pi_req)
    io_transfer_instruction(UNIT, OP_COND_IN, 18'h0);
    wb(1'b0, REG_AR_LO, 32'h0);
    `CHK("unit status", 32'h0000000b, rdat)
    io_transfer_instruction(UNIT, OP_SKIP_ZERO, 18'h8);
    `CHK("skip zero", 1'b0, rdat[ST_SKIP])
    io_transfer_instruction(UNIT, OP_SKIP_ONE, 18'h8);
    `CHK("skip one", 1'b1, rdat[ST_SKIP])
    io_transfer_instruction(UNIT, OP_DATA_IN, 18'h0);
    wb(1'b0, REG_AR_LO, 32'h0);
    `CHK("data in", item[31:0], rdat)
    `CHK("flag", 7'h00, bus.pi_req)
  endtask : t_unit
  task automatic t_out();
    ar(36'h9_1234_5678);
    io_transfer_instruction(UNIT, OP_DATA_OUT, 18'h0);
    `CHK("data out", 36'h9_1234_5678, odata)
    io_transfer_instruction(CPU_DEV_CODE, OP_DATA_OUT, 18'h0);
    `CHK("limits", 16'h9115, {bound, reloc})
    ar(36'h6_edcb_a987);
    io_transfer_instruction(UNIT, OP_BLOCK_OUT, 18'h0);
    `CHK("block out", 36'h6_edcb_a987, odata)
    io_transfer_instruction(CPU_DEV_CODE, OP_DATA_IN, 18'h0);
    wb(1'b0, REG_AR_LO, 32'h0);
    `CHK("switches", sw[31:0], rdat)
  endtask : t_out
  // forced low channel beats a real one, hold blocks, dismiss frees
  task automatic t_pi();
    put_item();
    wb(1'b1, REG_SEQ, 32'h1);
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK("req off", 7'h00, rdat[22:16])
    ar(36'h504);
    io_transfer_instruction(PI_DEV_CODE, OP_COND_OUT, 18'h0);
    ar(36'h81);
    io_transfer_instruction(PI_DEV_CODE, OP_COND_OUT, 18'h0);
    `CHK("forced req", 7'h01, rdat[22:16])
    io_transfer_instruction(PI_DEV_CODE, OP_COND_IN, 18'h0);
    wb(1'b0, REG_AR_LO, 32'h0);
    `CHK("pi status", 32'h00000084, rdat)
    wb(1'b1, REG_SEQ, 32'h1);
    `CHK("lowest", 19'h40022, {picyc, iaddr})
    wb(1'b1, REG_SEQ, 32'h4);
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK("hold req", 15'h0104, rdat[30:16])
    wb(1'b1, REG_SEQ, 32'h1);
    `CHK("held", 1'b0, picyc)
    ar(36'h2000);
    io_transfer_instruction(PI_DEV_CODE, OP_COND_OUT, 18'h0);
    `CHK("dismiss", 7'h00, rdat[30:24])
    wb(1'b1, REG_SEQ, 32'h1);
    `CHK("chan three", 19'h40026, {picyc, iaddr})
    io_transfer_instruction(UNIT, OP_BLOCK_IN, 18'h0);
    `CHK("resume", 8'h00, {picyc, rdat[22:16]})
  endtask : t_pi
  // processor flags on channel 2, block overflow, block move abort
  task automatic t_ovf();
    ar(36'h106);
    io_transfer_instruction(PI_DEV_CODE, OP_COND_OUT, 18'h0);
    ar(36'h2);
    io_transfer_instruction(CPU_DEV_CODE, OP_COND_OUT, 18'h0);
    flt <= 6'h08;
    @(posedge mclk);
    flt <= 6'h00;
    wb(1'b1, REG_SEQ, 32'h1);
    `CHK("clock off", 1'b0, picyc)
    flt <= 6'h01;
    @(posedge mclk);
    flt <= 6'h00;
    wb(1'b1, REG_SEQ, 32'h1);
    `CHK("fault req", 19'h40024, {picyc, iaddr})
    wb(1'b1, REG_BLKCNT, 32'h3ffff);
    io_transfer_instruction(UNIT, OP_BLOCK_IN, 18'h0);
    `CHK("second cycle", 20'hc0025, {rdat[ST_PI_OVF], picyc, iaddr})
    wb(1'b1, REG_SEQ, 32'h4);
    ar(36'h2000);
    io_transfer_instruction(PI_DEV_CODE, OP_COND_OUT, 18'h0);
    wb(1'b1, REG_BLT_LO, 32'h00031234);
    wb(1'b1, REG_SEQ, 32'h2);
    wb(1'b0, REG_AR_LO, 32'h0);
    `CHK("saved pointer", 32'h00031234, rdat)
  endtask : t_ovf
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // main sequence, then a watchdog well beyond its length
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    t_unit();
    t_out();
    t_pi();
    t_ovf();
    finish_test();
  end
  initial begin
    #20000;
    bad_count++;
    finish_test();
  end
endmodule : io_bus_command_and_priority_interrupt_tb
`default_nettype wire
